/* File: rtl/epd_cmd_ctrl.sv */
// Command decoder for window mode, OTP program/readback, chain and power options.
// Assumes link pins are sampled by link_clk and refresh inputs share clk_sys.
`timescale 1ns/1ns
module epd_cmd_ctrl
    import epd_cmd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic link_clk,
    input wire logic chip_select_low,
    input wire logic cmd_or_param_select,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [7:0] burn_data,
    output logic [12:0] burn_addr,
    input wire logic [7:0] sensor_temp,
    input wire logic vcom_pol,
    input wire logic src_pol,
    input wire logic line_tick,
    output logic window_mode,
    output logic otp_write_mode,
    output logic busy_n,
    output logic [7:0] status_byte,
    output logic slave_tick_out,
    output logic chain_tick_enable,
    output logic forced_temp_select,
    output logic [7:0] temp_value,
    output logic [7:0] forced_temp_value,
    output logic [3:0] vcom_saving_width,
    output logic [3:0] column_saving_width,
    output logic vcom_saving,
    output logic column_saving,
    output logic [1:0] undervoltage_threshold
);

    // *************************************************
    // State
    // *************************************************
    typedef struct packed {
        logic [2:0] tsync;
        logic [7:0] cmd;
        logic [2:0] idx;
        logic window;
        logic prog;
        burn_e burn;
        logic [12:0] baddr;
        logic [3:0] bcnt;
        logic [12:0] otp_range_first;
        logic [12:0] range_last;
        logic [12:0] last_prog;
        logic rd_mode;
        logic [12:0] rd_addr;
        logic [7:0] tx;
        logic tick_en;
        logic forced_sel;
        logic [7:0] forced_t;
        logic [7:0] saving;
        logic [1:0] lvd;
        logic [3:0] div;
        logic tick;
        logic [3:0] unit;
        logic vpol;
        logic spol;
    } ctl_s;

    ctl_s s_reg;
    ctl_s s_next;
    logic [7:0] otp_mem [OTP_DEPTH];
    link_byte_s rx_word;
    logic rx_toggle;
    logic byte_evt;
    logic burn_write;
    logic [12:0] read_limit;
    logic src_tick;

    serial_link u_link (
        .link_clk(link_clk),
        .resetn(resetn),
        .chip_select_low(chip_select_low),
        .cmd_or_param_select(cmd_or_param_select),
        .sda_in(sda_in),
        .rd_mode(s_reg.rd_mode),
        .tx_byte(s_reg.tx),
        .rx_word(rx_word),
        .rx_toggle(rx_toggle),
        .sda_out(sda_out),
        .sda_oe(sda_oe)
    );

    // New byte seen once the toggle is past both synchroniser stages
    assign byte_evt = s_reg.tsync[1] ^ s_reg.tsync[2];
    assign read_limit = (s_reg.last_prog > READ_MAX_ADDR) ? READ_MAX_ADDR : s_reg.last_prog;
    assign burn_write = (s_reg.burn == BURN_RUN) && (s_reg.bcnt == BURN_CYC - 4'h1);
    assign src_tick = (s_reg.unit == SRC_UNIT_CYC - 4'h1);

    // *************************************************
    // Next-state logic
    // *************************************************
    always_comb begin
        s_next = s_reg;
        s_next.tsync = {s_reg.tsync[1:0], rx_toggle};
        if (byte_evt && !rx_word.is_param) begin
            s_next.cmd = rx_word.data;
            s_next.idx = 3'h0;
            s_next.rd_mode = 1'b0;
            case (rx_word.data)
                WINDOW_IN: s_next.window = 1'b1;
                WINDOW_OUT: s_next.window = 1'b0;
                OTP_WRITE_ENTRY: s_next.prog = 1'b1;
                OTP_BURN_START: begin
                    if (s_reg.prog && s_reg.burn == BURN_IDLE) begin
                        s_next.burn = BURN_RUN;
                        s_next.baddr = s_reg.otp_range_first;
                        s_next.bcnt = 4'h0;
                    end
                end
                OTP_READBACK: begin
                    s_next.rd_mode = 1'b1;
                    s_next.tx = otp_mem[0];
                    s_next.rd_addr = 13'h0001;
                end
                default: begin
                end
            endcase
        end else if (byte_evt) begin
            if (s_reg.idx != PARAM_IDX_MAX) begin
                s_next.idx = s_reg.idx + 3'h1;
            end
            if (s_reg.rd_mode) begin
                if (s_reg.rd_addr <= read_limit) begin
                    s_next.tx = otp_mem[s_reg.rd_addr];
                    s_next.rd_addr = s_reg.rd_addr + 13'h0001;
                end else begin
                    s_next.tx = READ_PAST_END;
                end
            end
            case (s_reg.cmd)
                OTP_RANGE: begin
                    case (s_reg.idx)
                        3'h0: s_next.otp_range_first[12:8] = rx_word.data[4:0];
                        3'h1: s_next.otp_range_first[7:0] = rx_word.data;
                        3'h2: s_next.range_last[12:8] = rx_word.data[4:0];
                        3'h3: s_next.range_last[7:0] = rx_word.data;
                        default: begin
                        end
                    endcase
                end
                CHAIN_OPTION: begin
                    if (s_reg.idx == 3'h0) begin
                        s_next.tick_en = rx_word.data[CHAIN_TICK_BIT];
                        s_next.forced_sel = rx_word.data[FORCED_SEL_BIT];
                    end
                end
                POLARITY_SAVING: begin
                    if (s_reg.idx == 3'h0) begin
                        s_next.saving = rx_word.data;
                    end
                end
                UNDERVOLTAGE_LEVEL: begin
                    if (s_reg.idx == 3'h0) begin
                        s_next.lvd = rx_word.data[1:0];
                    end
                end
                FORCED_TEMP: begin
                    if (s_reg.idx == 3'h0) begin
                        s_next.forced_t = rx_word.data;
                    end
                end
                default: begin
                end
            endcase
        end
        if (s_reg.burn == BURN_RUN) begin
            s_next.bcnt = burn_write ? 4'h0 : s_reg.bcnt + 4'h1;
            if (burn_write) begin
                if (s_reg.baddr == s_reg.range_last) begin
                    s_next.burn = BURN_IDLE;
                    s_next.last_prog = s_reg.baddr;
                end else begin
                    s_next.baddr = s_reg.baddr + 13'h0001;
                end
            end
        end
        // Slave clock divider; held low when disabled
        if (!s_reg.tick_en) begin
            s_next.div = 4'h0;
            s_next.tick = 1'b0;
        end else if (s_reg.div == CHAIN_HALF_CYC - 4'h1) begin
            s_next.div = 4'h0;
            s_next.tick = ~s_reg.tick;
        end else begin
            s_next.div = s_reg.div + 4'h1;
        end
        s_next.unit = src_tick ? 4'h0 : s_reg.unit + 4'h1;
        s_next.vpol = vcom_pol;
        s_next.spol = src_pol;
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s_reg <= '0;
            s_reg.burn <= BURN_IDLE;
            s_reg.saving <= SAVING_RESET;
            s_reg.lvd <= UNDERVOLTAGE_RESET;
            s_reg.last_prog <= READ_MAX_ADDR;
        end else begin
            s_reg <= s_next;
        end
    end

    // Array kept outside the state record; not cleared by reset
    always_ff @(posedge clk_sys) begin
        if (burn_write) begin
            otp_mem[s_reg.baddr] <= burn_data;
        end
    end

    // *************************************************
    // Power-saving intervals
    // *************************************************
    // open on reversal
    width_timer u_vcom_save (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .trig(vcom_pol ^ s_reg.vpol),
        .unit_tick(line_tick),
        .width(s_reg.saving[7:4]),
        .active(vcom_saving)
    );

    width_timer u_col_save (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .trig(src_pol ^ s_reg.spol),
        .unit_tick(src_tick),
        .width(s_reg.saving[3:0]),
        .active(column_saving)
    );

    // *************************************************
    // Outputs
    // *************************************************
    assign window_mode = s_reg.window;
    assign otp_write_mode = s_reg.prog;
    assign busy_n = (s_reg.burn == BURN_IDLE);
    always_comb begin
        status_byte = 8'h00;
        status_byte[STATUS_BUSY_BIT] = busy_n;
        status_byte[STATUS_WINDOW_BIT] = s_reg.window;
    end
    assign burn_addr = s_reg.baddr;
    assign slave_tick_out = s_reg.tick;
    assign chain_tick_enable = s_reg.tick_en;
    assign forced_temp_select = s_reg.forced_sel;
    assign forced_temp_value = s_reg.forced_t;
    assign temp_value = s_reg.forced_sel ? s_reg.forced_t : sensor_temp;
    assign vcom_saving_width = s_reg.saving[7:4];
    assign column_saving_width = s_reg.saving[3:0];
    assign undervoltage_threshold = s_reg.lvd;

    // *************************************************
    // Assertions
    // *************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    logic cmd_evt;
    assign cmd_evt = byte_evt && !rx_word.is_param;

    win_entry_a: assert property (cmd_evt && rx_word.data == WINDOW_IN |=> ##1 window_mode)
        else $error("window mode not entered");
    win_exit_a: assert property (cmd_evt && rx_word.data == WINDOW_OUT |=> !window_mode)
        else $error("window mode not left");
    prog_entry_a: assert property (cmd_evt && rx_word.data == OTP_WRITE_ENTRY |=> otp_write_mode)
        else $error("program mode not entered");
    prog_hold_a: assert property (otp_write_mode |=> otp_write_mode)
        else $error("program mode left without reset");
    burn_busy_a: assert property ($rose(s_reg.burn == BURN_RUN) |-> !busy_n [*3])
        else $error("busy released early");
    burn_end_a: assert property ($rose(busy_n) |-> $past(s_reg.baddr) == s_reg.range_last)
        else $error("burn ended off range end");
    status_bit_a: assert property (status_byte[0] == busy_n && status_byte[6] == window_mode)
        else $error("status byte mismatch");
    read_start_a: assert property (cmd_evt && rx_word.data == OTP_READBACK
        |=> s_reg.rd_addr == 13'h0001 && s_reg.rd_mode)
        else $error("readback start wrong");
    read_cap_a: assert property (s_reg.rd_mode |-> s_reg.rd_addr <= read_limit + 13'h0001)
        else $error("readback beyond limit");
    range_end_a: assert property (byte_evt && rx_word.is_param && s_reg.cmd == OTP_RANGE
        && s_reg.idx == 3'h3 |=> s_reg.range_last[7:0] == $past(rx_word.data))
        else $error("range end not stored");
    tick_low_a: assert property (!chain_tick_enable |=> !slave_tick_out)
        else $error("slave clock while disabled");
    temp_src_a: assert property (forced_temp_select |-> temp_value == forced_temp_value)
        else $error("forced temperature not used");
    vcom_save_a: assert property ($changed(vcom_pol) && vcom_saving_width != 4'h0
        |=> vcom_saving)
        else $error("saving interval missing");

    burn_cov: cover property ($fell(busy_n) ##[1:1000] $rose(busy_n));
    read_cov: cover property (s_reg.rd_mode && byte_evt ##1 s_reg.rd_addr == 13'h0003);
    chain_cov: cover property ($rose(slave_tick_out));
    save_cov: cover property ($rose(column_saving));

endmodule

/* File: inc/epd_cmd_pkg.sv */
// Constants, field layouts and carrier types for the display command decoder.
// Assumes a 10 MHz system clock and a serial link clocked by the host.
package epd_cmd_pkg;

    // *************************************************
    // Command bytes
    // *************************************************
    localparam logic [7:0] WINDOW_IN = 8'h91;
    localparam logic [7:0] WINDOW_OUT = 8'h92;
    localparam logic [7:0] OTP_WRITE_ENTRY = 8'ha0;
    localparam logic [7:0] OTP_BURN_START = 8'ha1;
    localparam logic [7:0] OTP_READBACK = 8'ha2;
    localparam logic [7:0] OTP_RANGE = 8'ha3;
    localparam logic [7:0] CHAIN_OPTION = 8'he0;
    localparam logic [7:0] POLARITY_SAVING = 8'he3;
    localparam logic [7:0] UNDERVOLTAGE_LEVEL = 8'he4;
    localparam logic [7:0] FORCED_TEMP = 8'he5;

    // *************************************************
    // Fields, reset values, address space
    // *************************************************
    localparam int CHAIN_TICK_BIT = 0;
    localparam int FORCED_SEL_BIT = 1;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_WINDOW_BIT = 6;
    localparam logic [7:0] SAVING_RESET = 8'h00;
    localparam logic [1:0] UNDERVOLTAGE_RESET = 2'h3;
    localparam int OTP_DEPTH = 8192;
    localparam logic [12:0] READ_MAX_ADDR = 13'h0fff;
    localparam logic [7:0] READ_PAST_END = 8'h00;
    localparam logic [2:0] PARAM_IDX_MAX = 3'h7;

    // *************************************************
    // Timing
    // *************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int SRC_UNIT_NS = 650;
    localparam logic [3:0] SRC_UNIT_CYC = 4'((SRC_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int BURN_TIME_NS = 1000;
    localparam logic [3:0] BURN_CYC = 4'((BURN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] CHAIN_HALF_CYC = 4'h1;

    // One received byte with its command/parameter flag
    typedef struct packed {
        logic [7:0] data;
        logic is_param;
    } link_byte_s;

    typedef enum logic {BURN_IDLE, BURN_RUN} burn_e;

endpackage

/* File: rtl/width_timer.sv */
// Saving-interval timer: opens an interval of a programmed number of units.
// Assumes trigger and unit tick are one-cycle pulses on clk_sys.
`timescale 1ns/1ns
module width_timer
    import epd_cmd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic trig,
    input wire logic unit_tick,
    input wire logic [3:0] width,
    output logic active
);

    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;

    // Reload on reversal, count down on unit ticks
    always_comb begin
        cnt_next = cnt_reg;
        if (trig) begin
            cnt_next = width;
        end else if (unit_tick && cnt_reg != 4'h0) begin
            cnt_next = cnt_reg - 4'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cnt_reg <= 4'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // Zero width means no interval at all
    assign active = (cnt_reg != 4'h0);

endmodule

/* File: rtl/serial_link.sv */
// Serial byte engine on the host's clock: shifts bytes in, shifts read data out.
// Assumes the link clock is idle whenever chip_select_low is high.
`timescale 1ns/1ns
module serial_link
    import epd_cmd_pkg::*;
(
    input wire logic link_clk,
    input wire logic resetn,
    input wire logic chip_select_low,
    input wire logic cmd_or_param_select,
    input wire logic sda_in,
    input wire logic rd_mode,
    input wire logic [7:0] tx_byte,
    output link_byte_s rx_word,
    output logic rx_toggle,
    output logic sda_out,
    output logic sda_oe
);

    logic [2:0] bit_reg;
    logic [6:0] shift_reg;
    logic [7:0] tx_hold_reg;
    logic rd_meta_reg;
    logic rd_sync_reg;

    // Bit count restarts with every frame; no clock edge exists to do it
    always_ff @(posedge link_clk or posedge chip_select_low or negedge resetn) begin
        if (!resetn) begin
            bit_reg <= 3'h0;
        end else if (chip_select_low) begin
            bit_reg <= 3'h0;
        end else begin
            bit_reg <= bit_reg + 3'h1;
        end
    end

    // Byte assembly, event toggle and read-data capture
    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            shift_reg <= 7'h00;
            rx_word <= '0;
            rx_toggle <= 1'b0;
            tx_hold_reg <= 8'h00;
            rd_meta_reg <= 1'b0;
            rd_sync_reg <= 1'b0;
        end else begin
            shift_reg <= {shift_reg[5:0], sda_in};
            rd_meta_reg <= rd_mode;
            rd_sync_reg <= rd_meta_reg;
            if (bit_reg == 3'h7) begin
                rx_word <= '{data: {shift_reg, sda_in}, is_param: cmd_or_param_select};
                rx_toggle <= ~rx_toggle;
                // Word held steady by the system side until this edge
                tx_hold_reg <= tx_byte;
            end
        end
    end

    // Read data most significant bit first
    assign sda_out = tx_hold_reg[3'h7 - bit_reg];
    assign sda_oe = rd_sync_reg & cmd_or_param_select & ~chip_select_low;

endmodule

/* File: verification/host_link_model.sv */
// Host side of the serial command link: frames command and parameter bytes.
// Assumes the bench merges host_sda with the design's sda_out by sda_oe.
`timescale 1ns/1ns
module host_link_model (
    output logic link_clk,
    output logic chip_select_low,
    output logic cmd_or_param_select,
    output logic host_sda,
    input wire logic sda_line
);
    // ***********************************
    // Byte framing
    // ***********************************
    initial begin
        link_clk = 1'b0;
        chip_select_low = 1'b1;
        cmd_or_param_select = 1'b0;
        host_sda = 1'b1;
    end

    // Link clock runs only inside a byte; gap keeps byte period over 600 ns
    task automatic shift_byte(input logic dc, input logic rd, input logic [7:0] b,
                              input int half, output logic [7:0] got);
        cmd_or_param_select <= dc;
        for (int i = 7; i >= 0; i--) begin
            // Released line toggles so no stale level looks like data
            host_sda <= rd ? ~host_sda : b[i];
            #(half);
            got[i] = sda_line;
            link_clk <= 1'b1;
            #(half);
            link_clk <= 1'b0;
        end
        #1000;
    endtask

    task automatic send(input logic [7:0] c, input int n, input logic [31:0] p);
        logic [7:0] g;
        chip_select_low <= 1'b0;
        #50;
        shift_byte(1'b0, 1'b0, c, 6, g);
        // parameters in order, first byte in top bits
        for (int k = 0; k < n; k++) begin
            shift_byte(1'b1, 1'b0, p[31 - 8 * k -: 8], 6, g);
        end
        chip_select_low <= 1'b1;
        #100;
    endtask

    // Read bytes use a slow bit period so the device keeps up
    task automatic read_seq(input logic [7:0] c, input int n, output logic [31:0] q);
        logic [7:0] g;
        chip_select_low <= 1'b0;
        #50;
        shift_byte(1'b0, 1'b0, c, 6, g);
        for (int k = 0; k < n; k++) begin
            shift_byte(1'b1, 1'b1, 8'h00, 180, g);
            q[31 - 8 * k -: 8] = g;
        end
        chip_select_low <= 1'b1;
        #100;
    endtask
endmodule

/* File: verification/test_epd_otp_partial_cascade_cmds.sv */
// Self-checking bench for the command decoder behind the serial link.
// Assumes host_link_model is compiled first and the package is visible.
`timescale 1ns/1ns
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module test_epd_otp_partial_cascade_cmds import epd_cmd_pkg::*; ;
    // ***********************************
    // Signals and instances
    // ***********************************
    logic clk_sys, resetn, link_clk, chip_select_low, cmd_or_param_select, sda_in;
    logic sda_out, sda_oe, host_sda, vcom_pol, src_pol, line_tick;
    logic otp_write_mode, busy_n, window_mode, slave_tick_out, chain_tick_enable;
    logic forced_temp_select, vcom_saving, column_saving;
    logic [7:0] burn_data, sensor_temp, status_byte, temp_value, forced_temp_value;
    logic [12:0] burn_addr, first_addr, last_addr;
    logic [3:0] vcom_saving_width, column_saving_width;
    logic [1:0] undervoltage_threshold;
    logic [31:0] q;
    int mismatches = 0, total_checks = 0, cycles = 0, low_cnt = 0, n;

    // Wire level of the shared data pin
    assign sda_in = sda_oe ? sda_out : host_sda;

    epd_cmd_ctrl epd_cmd_ctrl_inst (.clk_sys(clk_sys), .resetn(resetn),
        .link_clk(link_clk), .chip_select_low(chip_select_low),
        .cmd_or_param_select(cmd_or_param_select), .sda_in(sda_in), .sda_out(sda_out),
        .sda_oe(sda_oe), .burn_data(burn_data), .burn_addr(burn_addr),
        .sensor_temp(sensor_temp), .vcom_pol(vcom_pol), .src_pol(src_pol),
        .line_tick(line_tick), .window_mode(window_mode), .otp_write_mode(otp_write_mode),
        .busy_n(busy_n), .status_byte(status_byte), .slave_tick_out(slave_tick_out),
        .chain_tick_enable(chain_tick_enable), .forced_temp_select(forced_temp_select),
        .temp_value(temp_value), .forced_temp_value(forced_temp_value),
        .vcom_saving_width(vcom_saving_width), .column_saving_width(column_saving_width),
        .vcom_saving(vcom_saving), .column_saving(column_saving),
        .undervoltage_threshold(undervoltage_threshold));

    host_link_model host_link_model_inst (.link_clk(link_clk),
        .chip_select_low(chip_select_low), .cmd_or_param_select(cmd_or_param_select),
        .host_sda(host_sda), .sda_line(sda_in));

    // ***********************************
    // Clock, stimulus helpers, watchdog
    // ***********************************
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Burn data follows the address so readback is predictable
    always @(posedge clk_sys) begin
        cycles++;
        burn_data <= burn_addr[7:0] ^ 8'ha5;
        line_tick <= (cycles % 8 == 0);
        if (busy_n === 1'b0) begin
            low_cnt++;
            last_addr = burn_addr;
            if (low_cnt == 1) first_addr = burn_addr;
        end
        if (cycles == 40000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic close_out();
        if (mismatches == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic settle();
        repeat (10) @(posedge clk_sys);
    endtask

    // ***********************************
    // Scenarios
    // ***********************************
    task automatic t_window();
        host_link_model_inst.send(WINDOW_IN, 0, 32'h0);
        settle();
        `CHK(window_mode, 1'b1)
        `CHK(status_byte, 8'h41)
        host_link_model_inst.send(WINDOW_OUT, 0, 32'h0);
        settle();
        `CHK(window_mode, 1'b0)
        `CHK(status_byte, 8'h01)
    endtask

    task automatic t_chain();
        host_link_model_inst.send(CHAIN_OPTION, 1, 32'hfd00_0000);
        settle();
        `CHK({chain_tick_enable, forced_temp_select}, 2'b10)
        n = 0;
        repeat (6) @(posedge clk_sys) n += slave_tick_out;
        `CHK(n > 0 && n < 6, 1'b1)
        host_link_model_inst.send(FORCED_TEMP, 1, 32'h5a00_0000);
        host_link_model_inst.send(CHAIN_OPTION, 1, 32'h0200_0000);
        settle();
        `CHK(forced_temp_value, 8'h5a)
        `CHK(temp_value, 8'h5a)
        `CHK(slave_tick_out, 1'b0)
        host_link_model_inst.send(CHAIN_OPTION, 1, 32'h0);
        settle();
        `CHK(temp_value, 8'h3c)
    endtask

    task automatic t_level();
        // Last value written differs from the reset value
        for (int v = 3; v >= 0; v--) begin
            host_link_model_inst.send(UNDERVOLTAGE_LEVEL, 1, {6'h2a, 2'(v), 24'h0});
            settle();
            `CHK(undervoltage_threshold, 2'(v))
        end
        host_link_model_inst.send(UNDERVOLTAGE_LEVEL, 0, 32'h0);
        settle();
        `CHK(undervoltage_threshold, 2'h0)
    endtask

    // Widths 2 units each; unit ticks run free, so one unit of slack
    task automatic t_saving();
        host_link_model_inst.send(POLARITY_SAVING, 1, 32'h2200_0000);
        host_link_model_inst.send(POLARITY_SAVING, 0, 32'h0);
        settle();
        `CHK({vcom_saving_width, column_saving_width}, 8'h22)
        src_pol <= ~src_pol;
        repeat (2) @(posedge clk_sys);
        `CHK(column_saving, 1'b1)
        n = 1;
        repeat (30) @(posedge clk_sys) n += column_saving;
        `CHK(n >= 8 && n <= 15, 1'b1)
        vcom_pol <= ~vcom_pol;
        repeat (2) @(posedge clk_sys);
        n = 0;
        repeat (40) @(posedge clk_sys) n += vcom_saving;
        `CHK(n >= 8 && n <= 17, 1'b1)
    endtask

    task automatic t_otp();
        host_link_model_inst.send(OTP_BURN_START, 0, 32'h0);
        settle();
        `CHK(low_cnt, 0)
        host_link_model_inst.send(OTP_RANGE, 4, 32'he000_e001);
        host_link_model_inst.send(OTP_WRITE_ENTRY, 0, 32'h0);
        settle();
        `CHK(otp_write_mode, 1'b1)
        host_link_model_inst.send(OTP_BURN_START, 0, 32'h0);
        n = 0;
        while (busy_n !== 1'b1 && n < 100) @(posedge clk_sys) n++;
        settle();
        `CHK(low_cnt, 2 * int'(BURN_CYC))
        `CHK({first_addr, last_addr}, {13'h0, 13'h1})
        `CHK(otp_write_mode, 1'b1)
        host_link_model_inst.read_seq(OTP_READBACK, 4, q);
        `CHK(q[23:0], 24'ha5a400)
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        settle();
        `CHK({otp_write_mode, busy_n}, 2'b01)
        // Second bank, one address at its very top
        low_cnt = 0;
        host_link_model_inst.send(OTP_RANGE, 4, 32'h1fff_1fff);
        host_link_model_inst.send(OTP_WRITE_ENTRY, 0, 32'h0);
        host_link_model_inst.send(OTP_BURN_START, 0, 32'h0);
        n = 0;
        while (busy_n !== 1'b1 && n < 100) @(posedge clk_sys) n++;
        `CHK({first_addr, last_addr}, {13'h1fff, 13'h1fff})
        `CHK(low_cnt, int'(BURN_CYC))
    endtask

    initial begin
        // Deferred so the link flops see a real falling edge
        resetn <= 1'b0;
        vcom_pol = 1'b0;
        src_pol = 1'b0;
        line_tick = 1'b0;
        burn_data = 8'h00;
        sensor_temp = 8'h3c;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        settle();
        `CHK({window_mode, otp_write_mode, busy_n, slave_tick_out}, 4'b0010)
        `CHK({chain_tick_enable, forced_temp_select}, 2'b00)
        `CHK({vcom_saving_width, column_saving_width}, SAVING_RESET)
        `CHK(undervoltage_threshold, UNDERVOLTAGE_RESET)
        t_window();
        t_chain();
        t_level();
        t_saving();
        t_otp();
        close_out();
    end
endmodule
